// >>> logic/irq_status_collector.sv
// Interrupt status collector: sticky event flags, enable mask, master request line.
// Assumes event strobes are synchronous to ref_clk, one cycle per event.
//
// How it works
// - Writing one clears a status bit.
// - Bit 31 sets from software event enable.
// - Bit 25 sets when stop requested and halted.
// - Bit 24 sets when receiver halts.
// - Bit 23 sets on dropped counter halfway.
// - Bit 21 sets when notify buffer loaded.
// - Bit 20 sets when receive transfer count done.
// - Bit 19 sets when timer wraps to FFFFh.
// - Bit 18 mirrors line interface request, read-only.
// - Bit 17 sets on power event regardless.
// - Only byte test write leaves low power.
// - Power event bypasses deassertion hold-off.
// - Bit 16 sets on status FIFO overflow.
// - Bit 15 sets on oversize received packet.
// - Bit 14 sets on receive error.
// - Bit 13 sets on transmit error.
// - Bit 10 sets on write to full FIFO.
// - Bit 9 sets when space exceeds threshold.
// - Bit 8 sets when status FIFO full.
// - Bit 4 sets when receive status full.
// - Bit 7 sets at transmit status level.
// - Bit 3 sets at receive status level.
// - Bit 6 sets on each dropped frame.
// - Bits 2-0 set by pin events.
// - Status records events regardless of enable.
// - Master line when any enabled bit set.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps

module irq_status_collector
  import irq_status_pkg::*;
(
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic [irq_status_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [irq_status_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  output logic      [irq_status_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                              tx_halted,
  input  wire logic                              rx_halted,
  input  wire logic [31:0]                       dropped_count,
  input  wire logic                              dropped_count_inc,
  input  wire logic                              buffer_loaded,
  input  wire logic                              buffer_notify,
  input  wire logic                              rx_transfer_done,
  input  wire logic [15:0]                       timer_value,
  input  wire logic                              timer_dec,
  input  wire logic                              line_interface_req,
  input  wire logic                              power_event,
  input  wire logic                              tx_status_overflow,
  input  wire logic                              oversize_frame,
  input  wire logic                              receive_error,
  input  wire logic                              transmit_error,
  input  wire logic                              tx_data_write,
  input  wire logic                              tx_data_full,
  input  wire logic [7:0]                        tx_free_blocks,
  input  wire logic [7:0]                        tx_space_level,
  input  wire logic                              tx_status_full,
  input  wire logic                              tx_status_level,
  input  wire logic                              frame_dropped,
  input  wire logic                              rx_status_full,
  input  wire logic                              rx_status_level,
  input  wire logic [2:0]                        pin_events,
  output logic                                   master_irq,
  output logic                                   power_irq,
  output logic                                   tx_stop_req,
  output logic                                   low_power
);

  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic [DATA_W-1:0] enable_q;
  logic [2:0]        ctrl_q;
  logic [2:0]        ctrl_d;
  logic              low_power_q;
  logic              low_power_d;
  logic [DATA_W-1:0] rdata_q;
  logic              master_q;
  logic              power_q;
  logic [DATA_W-1:0] events;
  logic [DATA_W-1:0] clear_bits;
  logic [DATA_W-1:0] live;
  logic [DATA_W-1:0] rdata_d;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_status  = reg_wr && hit(reg_addr, INTERRUPT_STATUS_OFS);
  wire wr_enable  = reg_wr && hit(reg_addr, INTERRUPT_ENABLE_OFS);
  wire wr_byte    = reg_wr && hit(reg_addr, BYTE_TEST_OFS);
  wire wr_control = reg_wr && hit(reg_addr, CONTROL_OFS);

  // Counter step across the halfway point, seen on the old value
  wire half_cross = dropped_count_inc && (dropped_count == DROPPED_HALF_FROM);
  // Down-counter at zero decrementing lands on FFFFh
  wire timer_wrap = timer_dec && (timer_value == (TIMER_WRAP_TO + 16'h0001));
  wire space_ok   = tx_free_blocks > tx_space_level;

  always_comb begin
    events = '0;
    events[SOFTWARE_EVENT_BIT]  = ctrl_q[CTRL_SW_ENABLE_BIT];
    events[TRANSMIT_HALTED_BIT] = ctrl_q[CTRL_TX_STOP_BIT] && tx_halted;
    events[RECEIVE_HALTED_BIT]  = rx_halted;
    events[DROPPED_HALF_BIT]    = half_cross;
    events[BUFFER_LOADED_BIT]   = buffer_loaded && buffer_notify;
    events[RX_TRANSFER_BIT]     = rx_transfer_done;
    events[TIMER_WRAP_BIT]      = timer_wrap;
    events[POWER_EVENT_BIT]     = power_event;
    events[TX_STATUS_OVF_BIT]   = tx_status_overflow;
    events[OVERSIZE_FRAME_BIT]  = oversize_frame;
    events[RECEIVE_ERROR_BIT]   = receive_error;
    events[TRANSMIT_ERROR_BIT]  = transmit_error;
    events[TX_DATA_OVERRUN_BIT] = tx_data_write && tx_data_full;
    events[TX_SPACE_AVAIL_BIT]  = space_ok;
    events[TX_STATUS_FULL_BIT]  = tx_status_full;
    events[RX_STATUS_FULL_BIT]  = rx_status_full;
    events[TX_STATUS_LEVEL_BIT] = tx_status_level;
    events[RX_STATUS_LEVEL_BIT] = rx_status_level;
    events[FRAME_DROPPED_BIT]   = frame_dropped;
    events[PIN_EVENT_LSB +: PIN_EVENT_W] = pin_events;
  end

  // Ones clear only writable bits; events OR in after, so set wins
  assign clear_bits = wr_status ? (reg_wdata & W1C_MASK) : '0;
  // No enable gating here: status always captures its source
  assign status_d   = ((status_q & ~clear_bits) | events) & W1C_MASK;

  // Line interface bit is a live view, never stored
  always_comb begin
    live = status_q;
    live[LINE_INTERFACE_BIT] = line_interface_req;
  end

  assign ctrl_d = wr_control ? reg_wdata[2:0] : ctrl_q;

  // Low power is left only by a byte test write; a power event alone never wakes
  always_comb begin
    low_power_d = low_power_q;
    if (wr_control && reg_wdata[CTRL_LOW_POWER_BIT]) begin
      low_power_d = 1'b1;
    end
    if (wr_byte) begin
      low_power_d = 1'b0;
    end
  end

  assign rdata_d = !reg_rd ? '0 :
                   hit(reg_addr, INTERRUPT_STATUS_OFS) ? (live & IMPL_MASK) :
                   hit(reg_addr, INTERRUPT_ENABLE_OFS) ? (enable_q & IMPL_MASK) :
                   hit(reg_addr, BYTE_TEST_OFS)        ? BYTE_TEST_VALUE :
                   hit(reg_addr, CONTROL_OFS)          ? {29'h0, ctrl_q[2], ctrl_q[1:0]} :
                   '0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_q    <= STATUS_RESET;
      enable_q    <= ENABLE_RESET;
      ctrl_q      <= 3'h0;
      low_power_q <= 1'b0;
      rdata_q     <= '0;
      master_q    <= 1'b0;
      power_q     <= 1'b0;
    end else begin
      status_q    <= status_d;
      enable_q    <= wr_enable ? (reg_wdata & IMPL_MASK) : enable_q;
      ctrl_q      <= ctrl_d;
      low_power_q <= low_power_d;
      rdata_q     <= rdata_d;
      master_q    <= |(live & enable_q);
      // Separate path so the hold-off timer outside cannot delay it
      power_q     <= live[POWER_EVENT_BIT] && enable_q[POWER_EVENT_BIT];
    end
  end

  assign reg_rdata   = rdata_q;
  assign master_irq  = master_q;
  assign power_irq   = power_q;
  assign tx_stop_req = ctrl_q[CTRL_TX_STOP_BIT];
  assign low_power   = low_power_q;

endmodule

// >>> logic/irq_status_pkg.sv
// Constants for the interrupt status collector: offsets, bit positions, reset values.
// Assumes a 32-bit register port with read data one cycle after the read strobe.
package irq_status_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Byte offsets on the register port
  localparam logic [ADDR_W-1:0] INTERRUPT_STATUS_OFS = 8'h58;
  localparam logic [ADDR_W-1:0] INTERRUPT_ENABLE_OFS = 8'h5c;
  localparam logic [ADDR_W-1:0] BYTE_TEST_OFS        = 8'h64;
  localparam logic [ADDR_W-1:0] CONTROL_OFS          = 8'h70;

  localparam logic [DATA_W-1:0] BYTE_TEST_VALUE = 32'h87654321;
  localparam logic [DATA_W-1:0] STATUS_RESET    = 32'h00000000;
  localparam logic [DATA_W-1:0] ENABLE_RESET    = 32'h00000000;

  // Status bit positions
  localparam int unsigned SOFTWARE_EVENT_BIT   = 31;
  localparam int unsigned TRANSMIT_HALTED_BIT  = 25;
  localparam int unsigned RECEIVE_HALTED_BIT   = 24;
  localparam int unsigned DROPPED_HALF_BIT     = 23;
  localparam int unsigned BUFFER_LOADED_BIT    = 21;
  localparam int unsigned RX_TRANSFER_BIT      = 20;
  localparam int unsigned TIMER_WRAP_BIT       = 19;
  localparam int unsigned LINE_INTERFACE_BIT   = 18;
  localparam int unsigned POWER_EVENT_BIT      = 17;
  localparam int unsigned TX_STATUS_OVF_BIT    = 16;
  localparam int unsigned OVERSIZE_FRAME_BIT   = 15;
  localparam int unsigned RECEIVE_ERROR_BIT    = 14;
  localparam int unsigned TRANSMIT_ERROR_BIT   = 13;
  localparam int unsigned TX_DATA_OVERRUN_BIT  = 10;
  localparam int unsigned TX_SPACE_AVAIL_BIT   = 9;
  localparam int unsigned TX_STATUS_FULL_BIT   = 8;
  localparam int unsigned TX_STATUS_LEVEL_BIT  = 7;
  localparam int unsigned FRAME_DROPPED_BIT    = 6;
  localparam int unsigned RX_STATUS_FULL_BIT   = 4;
  localparam int unsigned RX_STATUS_LEVEL_BIT  = 3;
  localparam int unsigned PIN_EVENT_LSB        = 0;
  localparam int unsigned PIN_EVENT_W          = 3;

  // Writable-one-to-clear bits (bit 18 is read-only, reserved bits absent)
  localparam logic [DATA_W-1:0] W1C_MASK     = 32'h83bbe7df;
  localparam logic [DATA_W-1:0] IMPL_MASK    = 32'h83bfe7df;

  // Control register bits
  localparam int unsigned CTRL_SW_ENABLE_BIT = 0;
  localparam int unsigned CTRL_TX_STOP_BIT   = 1;
  localparam int unsigned CTRL_LOW_POWER_BIT = 2;

  localparam logic [31:0] DROPPED_HALF_FROM = 32'h7fffffff;
  localparam logic [15:0] TIMER_WRAP_TO     = 16'hffff;

endpackage

// >>> verif/irq_status_monitor.sv
// Checker for the status collector register port and its control outputs.
// Assumes it is bound to irq_status_collector and watches its ports only.
`timescale 1ns/1ps

module irq_status_monitor
  import irq_status_pkg::*;
(
  input wire logic                              ref_clk,
  input wire logic                              rst,
  input wire logic [irq_status_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [irq_status_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                              reg_wr,
  input wire logic                              reg_rd,
  input wire logic [irq_status_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                              receive_error,
  input wire logic                              tx_stop_req,
  input wire logic                              low_power
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire rd_sts  = reg_rd && reg_addr == INTERRUPT_STATUS_OFS;
  wire wr_sts  = reg_wr && reg_addr == INTERRUPT_STATUS_OFS;
  wire wr_wake = reg_wr && reg_addr == BYTE_TEST_OFS;
  wire mapped  = reg_addr == INTERRUPT_STATUS_OFS || reg_addr == INTERRUPT_ENABLE_OFS ||
                 reg_addr == BYTE_TEST_OFS || reg_addr == CONTROL_OFS;
  // One idle bus cycle may sit between the event and the read; a clear there would be legal
  sequence rxe_then_read;
    receive_error ##1 !(wr_sts && reg_wdata[RECEIVE_ERROR_BIT]) ##1 rd_sts;
  endsequence
  // The later cycles must be event free, or the bit may legally be set again
  sequence clr_then_read;
    (wr_sts && reg_wdata[RECEIVE_ERROR_BIT] && !receive_error) ##1 !receive_error ##1 (rd_sts && !receive_error);
  endsequence
  chk_rdata_idle: assert property (reg_rdata != '0 |-> $past(reg_rd)) else $error("read data outside read slot");
  chk_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  chk_byte_test: assert property (reg_rd && reg_addr == BYTE_TEST_OFS |=> reg_rdata == BYTE_TEST_VALUE)
    else $error("byte test value wrong");
  chk_reserved_zero: assert property (rd_sts |=> (reg_rdata & ~IMPL_MASK) == '0)
    else $error("reserved status bit set");
  chk_event_sticky: assert property (rxe_then_read |=> reg_rdata[RECEIVE_ERROR_BIT])
    else $error("receive error not recorded");
  chk_clear_one: assert property (clr_then_read |=> !reg_rdata[RECEIVE_ERROR_BIT])
    else $error("write one did not clear");
  chk_wake_write: assert property (wr_wake |=> !low_power) else $error("byte test write did not wake");
  chk_sleep_hold: assert property (low_power && !wr_wake |=> low_power)
    else $error("left low power without wake write");
  chk_stop_ctrl: assert property (reg_wr && reg_addr == CONTROL_OFS |=>
    tx_stop_req == $past(reg_wdata[CTRL_TX_STOP_BIT])) else $error("stop request not stored");
endmodule

bind irq_status_collector irq_status_monitor i_mon (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .receive_error, .tx_stop_req, .low_power);

// >>> verif/tb_ethernet_irq_status_collector.sv
// Self-checking bench for the status collector, driven over its register port.
// Assumes the package constants; event inputs are packed by status bit position.
`timescale 1ns/1ps

module tb_ethernet_irq_status_collector;
  import irq_status_pkg::*;
  logic        ref_clk, rst, reg_wr, reg_rd, alt, master_irq, power_irq, tx_stop_req, low_power;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, ev;
  int          fail_count, cmp_count, cyc;
  int          qual [6] = '{25, 23, 21, 19, 10, 9};
  // The alt flag spoils each qualifier but bit 25, whose stop request the control write clears, so that a lone strobe must not set its bit
  irq_status_collector i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_halted(ev[25]), .rx_halted(ev[24]),
    .dropped_count(alt ? 32'h7ffffffe : 32'h7fffffff), .dropped_count_inc(ev[23]),
    .buffer_loaded(ev[21]), .buffer_notify(!alt), .rx_transfer_done(ev[20]),
    .timer_value(alt ? 16'h0001 : 16'h0000), .timer_dec(ev[19]), .line_interface_req(ev[18]),
    .power_event(ev[17]), .tx_status_overflow(ev[16]), .oversize_frame(ev[15]), .receive_error(ev[14]),
    .transmit_error(ev[13]), .tx_data_write(ev[10]), .tx_data_full(!alt),
    .tx_free_blocks(ev[9] ? (alt ? 8'h08 : 8'h09) : 8'h00), .tx_space_level(8'h08),
    .tx_status_full(ev[8]), .tx_status_level(ev[7]), .frame_dropped(ev[6]), .rx_status_full(ev[4]),
    .rx_status_level(ev[3]), .pin_events(ev[2:0]), .master_irq(master_irq), .power_irq(power_irq),
    .tx_stop_req(tx_stop_req), .low_power(low_power));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp(n, e, reg_rdata);
  endtask
  task automatic pulse(input logic [31:0] v);
    @(posedge ref_clk);
    ev <= v;
    @(posedge ref_clk);
    ev <= '0;
  endtask
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // About 275 cycles are needed; the ceiling leaves a wide margin
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    {rst, reg_wr, reg_rd, alt, reg_addr, reg_wdata, ev} = {1'b1, 75'h0};
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rdc("byte_test", BYTE_TEST_OFS, BYTE_TEST_VALUE);
    rdc("status_reset", INTERRUPT_STATUS_OFS, STATUS_RESET);
    rdc("enable_reset", INTERRUPT_ENABLE_OFS, ENABLE_RESET);
    rdc("unmapped", 8'h60, 32'h0);
    wr(INTERRUPT_ENABLE_OFS, 32'hffffffff);
    rdc("enable_mask", INTERRUPT_ENABLE_OFS, 32'h83bfe7df);
    wr(INTERRUPT_ENABLE_OFS, 32'h0);
    $display("register test done");
    wr(CONTROL_OFS, 32'h2);
    rdc("control", CONTROL_OFS, 32'h2);
    for (int b = 0; b < 31; b++) if (W1C_MASK[b]) begin
      pulse(32'h1 << b);
      rdc("event_set", INTERRUPT_STATUS_OFS, 32'h1 << b);
      wr(INTERRUPT_STATUS_OFS, 32'hffffffff);
      rdc("event_clear", INTERRUPT_STATUS_OFS, 32'h0);
    end
    wr(CONTROL_OFS, 32'h0);
    alt <= 1'b1;
    foreach (qual[i]) begin
      pulse(32'h1 << qual[i]);
      rdc("qualifier", INTERRUPT_STATUS_OFS, 32'h0);
    end
    alt <= 1'b0;
    $display("event test done");
    wr(CONTROL_OFS, 32'h1);
    wr(CONTROL_OFS, 32'h0);
    rdc("sw_event", INTERRUPT_STATUS_OFS, 32'h80000000);
    wr(INTERRUPT_STATUS_OFS, 32'h80000000);
    rdc("sw_clear", INTERRUPT_STATUS_OFS, 32'h0);
    @(posedge ref_clk);
    ev <= 32'h1 << 18;
    wr(INTERRUPT_STATUS_OFS, 32'h1 << 18);
    rdc("live_kept", INTERRUPT_STATUS_OFS, 32'h1 << 18);
    @(posedge ref_clk);
    ev <= 32'h1 << 14;
    wr(INTERRUPT_STATUS_OFS, 32'h1 << 14);
    ev <= '0;
    rdc("set_beats_clear", INTERRUPT_STATUS_OFS, 32'h1 << 14);
    wr(INTERRUPT_STATUS_OFS, 32'hffffffff);
    rdc("live_off", INTERRUPT_STATUS_OFS, 32'h0);
    $display("special bit test done");
    wr(INTERRUPT_ENABLE_OFS, 32'h00024000);
    pulse(32'h1 << 14);
    repeat (2) @(posedge ref_clk);
    #1 cmp("master_irq", 32'h1, {31'h0, master_irq});
    pulse(32'h1 << 17);
    repeat (2) @(posedge ref_clk);
    #1 cmp("power_irq", 32'h1, {31'h0, power_irq});
    wr(INTERRUPT_STATUS_OFS, 32'h00024000);
    repeat (3) @(posedge ref_clk);
    #1 cmp("master_off", 32'h0, {31'h0, master_irq});
    cmp("power_off", 32'h0, {31'h0, power_irq});
    pulse(32'h1 << 13);
    repeat (2) @(posedge ref_clk);
    #1 cmp("master_masked", 32'h0, {31'h0, master_irq});
    $display("request line test done");
    wr(CONTROL_OFS, 32'h4);
    pulse(32'h1 << 17);
    wr(CONTROL_OFS, 32'h0);
    #1 cmp("still_low", 32'h1, {31'h0, low_power});
    wr(BYTE_TEST_OFS, 32'h0);
    #1 cmp("woken", 32'h0, {31'h0, low_power});
    $display("low power test done");
    close_out();
  end
endmodule
